// ===== ufmpp_pkg.sv
// Package for the flash parallel request port: constants, types and states
package ufmpp_pkg;

    localparam int unsigned CLK_PERIOD_NS = 25;
    // Request line low time, least and longest, in ns
    localparam int unsigned CMD_MIN_NS = 600;
    localparam int unsigned CMD_MAX_NS = 3000;
    localparam int unsigned BUSY_MAX_NS = 300;
    localparam int unsigned HOLD_MIN_NS = 600;
    // Cycle counts derived from the clock rate
    localparam int unsigned CMD_MIN_CYC = (CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CMD_MAX_CYC = CMD_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_MIN_CYC = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Full internal widths of the array
    localparam int unsigned FULL_ADDR_W = 9;
    localparam int unsigned FULL_DATA_W = 16;
    localparam int unsigned ARRAY_WORDS = 512;
    localparam int unsigned SECTOR_WORDS = 256;

    // Default operation times in cycles
    localparam int unsigned READ_CYC_DEF = 8;
    localparam int unsigned PROG_CYC_DEF = 64;
    localparam int unsigned ERASE_CYC_DEF = 20000;

    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef enum logic [3:0] {
        UFMPP_IDLE  = 4'h1,
        UFMPP_SETUP = 4'h2,
        UFMPP_WORK  = 4'h4,
        UFMPP_WAIT  = 4'h8
    } ufmpp_state_t;

    typedef enum logic [1:0] {
        UFMPP_OP_READ  = 2'h0,
        UFMPP_OP_WRITE = 2'h1,
        UFMPP_OP_ERASE = 2'h2
    } ufmpp_op_t;

    // Request lines after synchronisation, active high
    typedef struct packed {
        logic rd;
        logic wr;
        logic er;
    } ufmpp_req_t;

endpackage : ufmpp_pkg

// ===== ufmpp_req_model.sv
// Requester model that drives the flash request port
`timescale 1ns/10ps
module ufmpp_req_model (
    input wire logic clk,
    input wire logic busy_n,
    output logic read_req_n,
    output logic write_req_n,
    output logic erase_req_n,
    output logic [8:0] addr,
    output logic [15:0] write_word_in
);
    int lat;
    int low_cyc;
    initial begin
        {read_req_n, write_req_n, erase_req_n} = 3'h7;
        addr = 9'h000;
        write_word_in = 16'h0000;
    end
    // -------------------------------------------------------------------
    // One request: lines given as {read, write, erase}, low means asserted
    // -------------------------------------------------------------------
    task automatic do_op(input logic [2:0] lines_n, input logic [8:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        write_word_in = d;
        {read_req_n, write_req_n, erase_req_n} = lines_n;
        lat = 0;
        low_cyc = 0;
        for (int i = 1; i <= 30; i++) begin
            @(negedge clk);
            if (busy_n === 1'b0) low_cyc++;
            if (busy_n === 1'b0 && lat == 0) lat = i;
        end
        {read_req_n, write_req_n, erase_req_n} = 3'h7;
        // Released bus shows inverted values
        addr = ~a;
        write_word_in = ~d;
        while (busy_n !== 1'b1 && low_cyc < 3000) begin
            @(negedge clk);
            low_cyc++;
        end
    endtask : do_op
    // -------------------------------------------------------------------
    // Write request joined by a read request during setup
    // -------------------------------------------------------------------
    task automatic do_abort(input logic [8:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        write_word_in = d;
        write_req_n = 1'b0;
        repeat (8) @(negedge clk);
        read_req_n = 1'b0;
        low_cyc = 0;
        repeat (22) begin
            @(negedge clk);
            if (busy_n === 1'b0) low_cyc++;
        end
        {read_req_n, write_req_n, erase_req_n} = 3'h7;
        addr = ~a;
        write_word_in = ~d;
        repeat (4) @(negedge clk);
    endtask : do_abort
endmodule : ufmpp_req_model

// ===== ufmpp_top.sv
// Flash parallel request port with array, timing and busy handling
`timescale 1ns/10ps
// Functional notes
// - Read, write and erase requests are active low lines.
// - Busy goes low within 300 ns of the falling edge of an accepted request.
// - In read/write builds the internal oscillator enable is low in reset and high after it.
// - In read-only builds the internal oscillator enable stays low.
// - Access mode, address width up to 9 and data width up to 16 are build choices.
// - Busy stays low for the whole operation and rises when it completes.
// - After a read, data valid rises to mark the output as the last read word.
// - More than one request at once is not accepted, and a second request joining during setup aborts the operation; the array is not touched.
// - Erase sets every word of the sector chosen by the top address bit to all ones.
module ufmpp_top #(
    parameter bit READ_ONLY = 1'b0,
    parameter int unsigned ADDR_W = 9,
    parameter int unsigned DATA_W = 16,
    parameter int unsigned READ_CYC = ufmpp_pkg::READ_CYC_DEF,
    parameter int unsigned PROG_CYC = ufmpp_pkg::PROG_CYC_DEF,
    parameter int unsigned ERASE_CYC = ufmpp_pkg::ERASE_CYC_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic read_req_n,
    input wire logic write_req_n,
    input wire logic erase_req_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] write_word_in,
    output logic [DATA_W-1:0] read_word_out,
    output logic busy_n,
    output logic data_valid,
    output logic osc_ena
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] req_s1_reg;
    logic [2:0] req_s2_reg;
    logic [2:0] req_s3_reg;
    logic [ADDR_W-1:0] addr_s1_reg;
    logic [ADDR_W-1:0] addr_s2_reg;
    logic [DATA_W-1:0] din_s1_reg;
    logic [DATA_W-1:0] din_s2_reg;
    ufmpp_pkg::ufmpp_req_t req_now;
    ufmpp_pkg::ufmpp_req_t req_prev;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_s1_reg <= 3'h7;
            req_s2_reg <= 3'h7;
            req_s3_reg <= 3'h7;
        end else begin
            req_s1_reg <= {read_req_n, write_req_n, erase_req_n};
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
        end
    end

    always_ff @(posedge clk) begin
        addr_s1_reg <= addr;
        addr_s2_reg <= addr_s1_reg;
        din_s1_reg <= write_word_in;
        din_s2_reg <= din_s1_reg;
    end

    assign req_now = ufmpp_pkg::ufmpp_req_t'(~req_s2_reg);
    assign req_prev = ufmpp_pkg::ufmpp_req_t'(~req_s3_reg);

    function automatic logic [1:0] ufmpp_count(input ufmpp_pkg::ufmpp_req_t r);
        ufmpp_count = {1'b0, r.rd} + {1'b0, r.wr} + {1'b0, r.er};
    endfunction : ufmpp_count

    logic any_fall;
    assign any_fall = (req_now.rd & ~req_prev.rd) | (req_now.wr & ~req_prev.wr)
        | (req_now.er & ~req_prev.er);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    ufmpp_pkg::ufmpp_state_t state_reg;
    ufmpp_pkg::ufmpp_op_t op_reg;
    logic [15:0] hold_cnt_reg;
    logic [31:0] work_cnt_reg;
    logic [ufmpp_pkg::FULL_ADDR_W-1:0] op_addr_reg;
    logic [ufmpp_pkg::FULL_DATA_W-1:0] op_data_reg;
    logic [ufmpp_pkg::FULL_ADDR_W-1:0] full_addr;
    logic [ufmpp_pkg::FULL_DATA_W-1:0] full_din;
    logic single_req;
    logic [31:0] op_len;

    // Narrow buses pad low bits: address with zeros, data with ones
    assign full_addr = ufmpp_pkg::FULL_ADDR_W'(
        {addr_s2_reg, {(ufmpp_pkg::FULL_ADDR_W-ADDR_W+1){1'b0}}} >> 1);
    assign full_din = ufmpp_pkg::FULL_DATA_W'(
        {din_s2_reg, {(ufmpp_pkg::FULL_DATA_W-DATA_W+1){1'b1}}} >> 1);
    assign single_req = (ufmpp_count(req_now) == 2'h1);

    always_comb begin
        op_len = READ_CYC;
        if (op_reg == ufmpp_pkg::UFMPP_OP_WRITE) begin
            op_len = PROG_CYC;
        end else if (op_reg == ufmpp_pkg::UFMPP_OP_ERASE) begin
            op_len = ERASE_CYC;
        end
    end

    logic work_done;
    assign work_done = (state_reg == ufmpp_pkg::UFMPP_WORK) && (work_cnt_reg + 32'h1 >= op_len);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ufmpp_pkg::UFMPP_IDLE;
            op_reg <= ufmpp_pkg::UFMPP_OP_READ;
            hold_cnt_reg <= 16'h0000;
            work_cnt_reg <= 32'h0000_0000;
            op_addr_reg <= 9'h000;
            op_data_reg <= ufmpp_pkg::RESET_WORD;
        end else begin
            unique case (state_reg)
                ufmpp_pkg::UFMPP_IDLE: begin
                    hold_cnt_reg <= 16'h0000;
                    if (any_fall && single_req) begin
                        state_reg <= ufmpp_pkg::UFMPP_SETUP;
                        op_reg <= req_now.rd ? ufmpp_pkg::UFMPP_OP_READ
                            : (req_now.wr ? ufmpp_pkg::UFMPP_OP_WRITE : ufmpp_pkg::UFMPP_OP_ERASE);
                    end
                end
                ufmpp_pkg::UFMPP_SETUP: begin
                    // Sample bus late in the hold window
                    hold_cnt_reg <= hold_cnt_reg + 16'h0001;
                    if (!single_req && hold_cnt_reg < 16'(ufmpp_pkg::CMD_MIN_CYC - 4)) begin
                        state_reg <= ufmpp_pkg::UFMPP_WAIT;
                    end else if (hold_cnt_reg == 16'(ufmpp_pkg::HOLD_MIN_CYC - 4)) begin
                        op_addr_reg <= full_addr;
                        op_data_reg <= full_din;
                        work_cnt_reg <= 32'h0000_0000;
                        state_reg <= ufmpp_pkg::UFMPP_WORK;
                    end
                end
                ufmpp_pkg::UFMPP_WORK: begin
                    work_cnt_reg <= work_cnt_reg + 32'h0000_0001;
                    if (work_done) begin
                        state_reg <= ufmpp_pkg::UFMPP_WAIT;
                    end
                end
                ufmpp_pkg::UFMPP_WAIT: begin
                    // Let the request line rise before the next edge counts
                    if (ufmpp_count(req_now) == 2'h0) begin
                        state_reg <= ufmpp_pkg::UFMPP_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flash array
    // ------------------------------------------------------------
    logic [ufmpp_pkg::FULL_DATA_W-1:0] mem [0:ufmpp_pkg::ARRAY_WORDS-1];
    logic write_ok;
    assign write_ok = !READ_ONLY && work_done;

    always_ff @(posedge clk) begin
        if (write_ok && op_reg == ufmpp_pkg::UFMPP_OP_WRITE) begin
            // Programming can only clear bits
            mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg;
        end
        if (write_ok && op_reg == ufmpp_pkg::UFMPP_OP_ERASE) begin
            for (int i = 0; i < ufmpp_pkg::SECTOR_WORDS; i++) begin
                mem[{op_addr_reg[8], 8'(i)}] <= ufmpp_pkg::ERASED_WORD;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_n <= 1'b1;
        end else begin
            // Low from accepted edge until completion
            busy_n <= !((state_reg == ufmpp_pkg::UFMPP_IDLE && any_fall && single_req)
                || state_reg == ufmpp_pkg::UFMPP_SETUP
                || (state_reg == ufmpp_pkg::UFMPP_WORK && !work_done));
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_valid <= 1'b0;
            read_word_out <= '0;
        end else if (work_done && op_reg == ufmpp_pkg::UFMPP_OP_READ) begin
            data_valid <= 1'b1;
            read_word_out <= mem[op_addr_reg][ufmpp_pkg::FULL_DATA_W-1 -: DATA_W];
        end else if (state_reg == ufmpp_pkg::UFMPP_SETUP) begin
            data_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            osc_ena <= 1'b0;
        end else begin
            osc_ena <= !READ_ONLY;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    busy_fast_a: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ufmpp_pkg::UFMPP_IDLE && any_fall && single_req)
        |=> !busy_n) else $error("busy not low after accepted request");
    busy_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ufmpp_pkg::UFMPP_WORK && !work_done) |=> !busy_n)
        else $error("busy rose during operation");
    busy_rise_a: assert property (@(posedge clk) disable iff (!nrst)
        work_done |=> busy_n) else $error("busy did not rise at completion");
    valid_read_a: assert property (@(posedge clk) disable iff (!nrst)
        (work_done && op_reg == ufmpp_pkg::UFMPP_OP_READ) |=> data_valid)
        else $error("data valid missing after read");
    multi_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ufmpp_pkg::UFMPP_IDLE && ufmpp_count(req_now) > 2'h1)
        |=> state_reg != ufmpp_pkg::UFMPP_SETUP) else $error("multiple requests accepted");
    osc_mode_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> osc_ena == !READ_ONLY) else $error("oscillator enable wrong");
    ro_osc_off_a: assert property (@(posedge clk) disable iff (!nrst)
        (READ_ONLY && $past(nrst)) |-> !osc_ena)
        else $error("oscillator running in read-only build");
    ro_nowrite_a: assert property (@(posedge clk) disable iff (!nrst)
        READ_ONLY |-> !write_ok) else $error("array changed in read-only build");
    sample_time_a: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ufmpp_pkg::UFMPP_SETUP && $rose(state_reg == ufmpp_pkg::UFMPP_WORK) == 1'b0
        && $past(state_reg) == ufmpp_pkg::UFMPP_IDLE) |-> hold_cnt_reg == 16'h0000)
        else $error("hold count not cleared on entry");

endmodule : ufmpp_top

// ===== ufmpp_top_tb.sv
// Self-checking testbench for the flash parallel request port
`timescale 1ns/10ps
module ufmpp_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic read_req_n, write_req_n, erase_req_n, busy_n, data_valid, osc_ena;
    logic busy_n_ro, dv_ro, osc_ena_ro;
    logic [8:0] addr;
    logic [15:0] write_word_in, read_word_out, word_ro;
    int n_fail = 0;
    int checks_done = 0;
    initial forever #12.5 clk = ~clk;
    ufmpp_req_model model_u (.clk(clk), .busy_n(busy_n), .read_req_n(read_req_n),
        .write_req_n(write_req_n), .erase_req_n(erase_req_n), .addr(addr),
        .write_word_in(write_word_in));
    ufmpp_top #(.ERASE_CYC(50)) dut_u (.clk(clk), .nrst(nrst), .read_req_n(read_req_n),
        .write_req_n(write_req_n), .erase_req_n(erase_req_n), .addr(addr),
        .write_word_in(write_word_in), .read_word_out(read_word_out), .busy_n(busy_n),
        .data_valid(data_valid), .osc_ena(osc_ena));
    ufmpp_top #(.READ_ONLY(1'b1), .ERASE_CYC(50)) dut_ro_u (.clk(clk), .nrst(nrst),
        .read_req_n(read_req_n), .write_req_n(write_req_n), .erase_req_n(erase_req_n),
        .addr(addr), .write_word_in(write_word_in), .read_word_out(word_ro),
        .busy_n(busy_n_ro), .data_valid(dv_ro), .osc_ena(osc_ena_ro));
    // -------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("Counts: checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        model_u.do_op(3'h3, a, 16'h0000);
        check(read_word_out, exp);
        check({15'h0000, data_valid}, 16'h0001);
        check({15'h0000, dv_ro}, 16'h0001);
        check({15'h0000, model_u.low_cyc >= 8}, 16'h0001);
        check({15'h0000, busy_n}, 16'h0001);
        check({15'h0000, busy_n_ro}, 16'h0001);
    endtask : rd
    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_reset_osc();
        check({15'h0000, busy_n}, 16'h0001);
        check({15'h0000, data_valid}, 16'h0000);
        check({15'h0000, osc_ena}, 16'h0001);
        check({15'h0000, osc_ena_ro}, 16'h0000);
        $display("test reset_osc done");
    endtask : t_reset_osc
    task automatic t_erase();
        model_u.do_op(3'h6, 9'h005, 16'h0000);
        check({15'h0000, model_u.lat >= 1 && model_u.lat <= 12}, 16'h0001);
        model_u.do_op(3'h6, 9'h1C0, 16'h0000);
        check({15'h0000, model_u.low_cyc >= 50}, 16'h0001);
        rd(9'h0AB, 16'hFFFF);
        rd(9'h1FF, 16'hFFFF);
        $display("test erase done");
    endtask : t_erase
    task automatic t_write_read();
        model_u.do_op(3'h5, 9'h005, 16'h1234);
        check({15'h0000, model_u.lat >= 1 && model_u.lat <= 12}, 16'h0001);
        check({15'h0000, data_valid}, 16'h0000);
        rd(9'h005, 16'h1234);
        model_u.do_op(3'h5, 9'h005, 16'hFF0F);
        rd(9'h005, 16'h1204);
        rd(9'h1FF, 16'hFFFF);
        model_u.do_op(3'h6, 9'h100, 16'h0000);
        rd(9'h005, 16'h1204);
        check({15'h0000, osc_ena_ro}, 16'h0000);
        $display("test write_read done");
    endtask : t_write_read
    task automatic t_abort();
        model_u.do_abort(9'h005, 16'h0000);
        check({15'h0000, busy_n}, 16'h0001);
        check({15'h0000, data_valid}, 16'h0000);
        check({15'h0000, model_u.low_cyc < 8}, 16'h0001);
        rd(9'h005, 16'h1204);
        $display("test abort done");
    endtask : t_abort
    task automatic t_multi();
        logic [2:0] combos [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        foreach (combos[k]) begin
            model_u.do_op(combos[k], 9'h005, 16'h0000);
            check(16'(model_u.lat), 16'h0000);
        end
        rd(9'h005, 16'h1204);
        $display("test multi done");
    endtask : t_multi
    // -------------------------------------------------------------------
    // Main sequence and watchdog
    // -------------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        t_reset_osc();
        t_erase();
        t_write_read();
        t_multi();
        t_abort();
        end_of_test();
    end
    initial begin
        #(25 * 20000);
        n_fail++;
        end_of_test();
    end
endmodule : ufmpp_top_tb
